// ===== logic/fsv_supervisor.sv
`timescale 1ns/1ps
module fsv_supervisor
#(
  parameter int unsigned SAG_FILTER_CYC = fsv_pkg::SAG_FILTER_CYC,
  parameter int unsigned RETRY_CYC      = fsv_pkg::RETRY_CYC
)
(
  input  wire logic                          i_ref_clk,
  input  wire logic                          i_sys_rst,
  input  wire logic                          i_clk_en,
  input  wire fsv_pkg::fsv_vin_cmp_t         i_vin_cmp,
  input  wire logic                          i_core_supply_undervolt,
  input  wire logic                          i_core_supply_below_por,
  input  wire logic                          i_boost_sag_cmp,
  input  wire logic                          i_boost_over_cmp,
  input  wire logic                          i_chip_select_pin,
  input  wire logic                          i_io_supply_enable_pin,
  input  wire logic [1:0]                    i_input_undervolt_threshold_sel,
  input  wire fsv_pkg::fsv_masks_t           i_masks,
  input  wire logic                          i_i2c_mode,
  input  wire logic                          i_fault_clear,
  input  wire logic                          i_soft_start_done,
  input  wire logic                          i_adaptive_mode,
  input  wire logic [fsv_pkg::BOOST_W-1:0]   i_boost_adapt_target,
  input  wire logic [fsv_pkg::BOOST_W-1:0]   i_boost_init_setting,
  output fsv_pkg::fsv_faults_t               o_faults,
  output fsv_pkg::fsv_state_t                o_state,
  output fsv_pkg::fsv_power_t                o_power,
  output logic [fsv_pkg::BOOST_W-1:0]        o_boost_target,
  output logic                               o_fault_pin_o,
  output logic                               o_fault_pin_oe,
  output logic                               o_volatile_clear,
  output logic                               o_preserved_clear
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  localparam int SYNC_W = 9;

  logic [SYNC_W-1:0]     sync_1_q;
  logic [SYNC_W-1:0]     sync_2_q;
  fsv_pkg::fsv_vin_cmp_t vin_s;
  logic                  core_uv_s;
  logic                  core_por_s;
  logic                  sag_s;
  logic                  over_s;
  logic                  cs_s;
  logic                  en_s;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      sync_1_q <= '0;
      sync_2_q <= '0;
    end
    else if (i_clk_en)
    begin
      sync_1_q <= {i_vin_cmp, i_core_supply_undervolt,
                   i_core_supply_below_por, i_boost_sag_cmp,
                   i_boost_over_cmp, i_chip_select_pin,
                   i_io_supply_enable_pin};
      sync_2_q <= sync_1_q;
    end
  end

  assign {vin_s, core_uv_s, core_por_s, sag_s, over_s, cs_s, en_s} =
    sync_2_q;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic vin_low(input logic [1:0] sel,
                                   input fsv_pkg::fsv_vin_cmp_t cmp);
    case (sel)
      fsv_pkg::UV_SEL_3V: vin_low = cmp.below_3v;
      fsv_pkg::UV_SEL_5V: vin_low = cmp.below_5v;
      fsv_pkg::UV_SEL_8V: vin_low = cmp.below_8v;
      default:            vin_low = 1'b0;
    endcase
  endfunction

  // Set beats clear so a persisting fault is never lost
  function automatic logic sticky(input logic set,
                                  input logic q,
                                  input logic clr);
    sticky = set | (q & ~clr);
  endfunction

  // ****************************************************************
  // Fault detection
  // ****************************************************************
  fsv_pkg::fsv_state_t   state_q;
  fsv_pkg::fsv_state_t   state_d;
  fsv_pkg::fsv_faults_t  faults_q;
  fsv_pkg::fsv_faults_t  faults_d;
  fsv_pkg::fsv_power_t   power_d;
  logic                  watch;
  logic                  uv_set;
  logic                  sag_hit;
  logic                  ovp_set;
  logic                  retry_go;
  logic                  retry_done;
  logic                  clr_ev;
  logic                  por_ev;

  assign watch = (state_q == fsv_pkg::ST_SOFT) ||
                 (state_q == fsv_pkg::ST_RUN);

  // Off code and the mask both keep the bit, pin and retry quiet
  assign uv_set = watch && !i_masks.uv &&
                  vin_low(i_input_undervolt_threshold_sel, vin_s);

  // Boost runs from soft start on, so the filter runs there too
  fsv_hold_timer
  #(
    .CYCLES (SAG_FILTER_CYC)
  )
  u_sag_filter
  (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_clk_en  (i_clk_en),
    .i_run     (watch && sag_s),
    .o_done    (sag_hit)
  );

  assign ovp_set = (state_q == fsv_pkg::ST_RUN) && over_s &&
                   !i_masks.ovp_status;

  assign retry_go = uv_set ||
                    (sag_hit && !i_masks.sag_retry);

  // In I2C mode the select pin is a level clear; host must leave it low afterwards
  assign clr_ev = i_fault_clear || !en_s ||
                  (i_i2c_mode && cs_s);
  assign por_ev = core_por_s;

  always_comb
  begin
    faults_d.uv   = sticky(uv_set,  faults_q.uv,   clr_ev);
    faults_d.sag  = sticky(sag_hit, faults_q.sag,  clr_ev);
    faults_d.over = sticky(ovp_set, faults_q.over, clr_ev);
  end

  // A retry never clears bits; only the listed events do
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      faults_q <= fsv_pkg::FAULTS_RST;
    else if (i_clk_en)
    begin
      if (por_ev)
        faults_q <= fsv_pkg::FAULTS_RST;
      else
        faults_q <= faults_d;
    end
  end

  // ****************************************************************
  // Sequencing
  // ****************************************************************
  // Registered done costs one edge, so the timer counts one less
  fsv_hold_timer
  #(
    .CYCLES (RETRY_CYC - 1)
  )
  u_retry_timer
  (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_clk_en  (i_clk_en),
    .i_run     (state_q == fsv_pkg::ST_RETRY),
    .o_done    (retry_done)
  );

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      fsv_pkg::ST_OFF:
        state_d = fsv_pkg::ST_SOFT;
      fsv_pkg::ST_SOFT:
        if (retry_go)
          state_d = fsv_pkg::ST_RETRY;
        else if (i_soft_start_done)
          state_d = fsv_pkg::ST_RUN;
      fsv_pkg::ST_RUN:
        if (retry_go)
          state_d = fsv_pkg::ST_RETRY;
      fsv_pkg::ST_RETRY:
        if (retry_done)
          state_d = fsv_pkg::ST_SOFT;
      fsv_pkg::ST_STBY:
        state_d = fsv_pkg::ST_SOFT;
      default:
        state_d = fsv_pkg::ST_OFF;
    endcase
    // Supply loss overrides everything, then the enable pin
    if (core_uv_s || core_por_s)
      state_d = fsv_pkg::ST_STBY;
    else if (!en_s)
      state_d = fsv_pkg::ST_OFF;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      state_q <= fsv_pkg::ST_OFF;
    else if (i_clk_en)
      state_q <= state_d;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_comb
  begin
    power_d = fsv_pkg::POWER_OFF;
    if (state_d == fsv_pkg::ST_SOFT)
    begin
      power_d.boost  = 1'b1;
      power_d.pl_fet = 1'b1;
    end
    else if (state_d == fsv_pkg::ST_RUN)
    begin
      power_d.leds   = 1'b1;
      power_d.boost  = 1'b1;
      power_d.pl_fet = 1'b1;
    end
  end

  fsv_pkg::fsv_power_t         power_q;
  logic [fsv_pkg::BOOST_W-1:0] target_q;
  logic                        pin_oe_q;
  logic                        pin_o_q;
  logic                        vclr_q;
  logic                        pclr_q;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      power_q <= fsv_pkg::POWER_OFF;
    else if (i_clk_en)
      power_q <= power_d;
  end

  // Pin follows the bits; core undervoltage has no bit of its own
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      pin_oe_q <= 1'b0;
    else if (i_clk_en)
      pin_oe_q <= !por_ev && (|faults_d);
  end

  // Open drain: the pin is only ever pulled low
  always_ff @(posedge i_ref_clk)
  begin
    pin_o_q <= 1'b0;
  end

  // Comparators take the adaptive target in adaptive mode, else the initial setting
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      target_q <= '0;
    else if (i_clk_en)
      target_q <= i_adaptive_mode ? i_boost_adapt_target
                                  : i_boost_init_setting;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      vclr_q <= 1'b1;
      pclr_q <= 1'b1;
    end
    else if (i_clk_en)
    begin
      vclr_q <= core_uv_s || core_por_s;
      pclr_q <= core_por_s;
    end
  end

  assign o_faults          = faults_q;
  assign o_state           = state_q;
  assign o_power           = power_q;
  assign o_boost_target    = target_q;
  assign o_fault_pin_o     = pin_o_q;
  assign o_fault_pin_oe    = pin_oe_q;
  assign o_volatile_clear  = vclr_q;
  assign o_preserved_clear = pclr_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst || !i_clk_en);

  logic [fsv_pkg::TMR_W-1:0] retry_age_q;
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst || state_q != fsv_pkg::ST_RETRY)
      retry_age_q <= '0;
    else if (i_clk_en)
      retry_age_q <= retry_age_q + 1'b1;
  end

  sequence s_live;
    !core_uv_s && !core_por_s && en_s;
  endsequence

  sequence s_retry_exit;
    state_q == fsv_pkg::ST_RETRY ##1 state_q == fsv_pkg::ST_SOFT;
  endsequence

  a_uv_sel_off: assert property (
    (i_input_undervolt_threshold_sel == fsv_pkg::UV_SEL_OFF &&
     !faults_q.uv) |=> !faults_q.uv)
    else $error("undervoltage flagged with check off");

  a_uv_retry_pin: assert property (
    (uv_set and s_live) |=> (state_q == fsv_pkg::ST_RETRY) &&
                           faults_q.uv && o_fault_pin_oe)
    else $error("undervoltage did not retry and pull pin");

  a_bits_kept: assert property (
    (faults_q.uv && !clr_ev && !por_ev) |=> faults_q.uv)
    else $error("fault bit dropped without a clear event");

  a_uv_mask_all: assert property (
    (i_masks.uv && !faults_q.uv && !(state_q == fsv_pkg::ST_RETRY &&
     faults_q.sag)) |=> !faults_q.uv)
    else $error("masked undervoltage set its bit");

  a_clear_release: assert property (
    (clr_ev && !uv_set && !sag_hit && !ovp_set) |=>
    (faults_q == fsv_pkg::FAULTS_RST) && !o_fault_pin_oe)
    else $error("clear did not release bits and pin");

  a_stby_cycle: assert property (
    (core_uv_s && !core_por_s) |=> (state_q == fsv_pkg::ST_STBY) &&
    (o_power == fsv_pkg::POWER_OFF) ##1
    (s_live and (state_q == fsv_pkg::ST_STBY)) |=>
    state_q == fsv_pkg::ST_SOFT)
    else $error("standby entry or resume wrong");

  a_reg_clear: assert property (
    core_uv_s |=> o_volatile_clear && (o_preserved_clear == $past(core_por_s)))
    else $error("register clear strobes wrong");

  a_stby_noflag: assert property (
    (state_q == fsv_pkg::ST_STBY && !clr_ev && !por_ev) |=>
    $stable(faults_q))
    else $error("standby changed fault flags");

  a_sag_filter: assert property (
    $rose(faults_q.sag) |-> $past(sag_hit) && $past(sag_s, 2))
    else $error("sag flagged without filtered comparator");

  a_boost_target: assert property (
    ##1 o_boost_target == ($past(i_adaptive_mode) ?
        $past(i_boost_adapt_target) : $past(i_boost_init_setting)))
    else $error("boost target source wrong");

  a_sag_retry: assert property (
    (sag_hit and s_live) |=> faults_q.sag && o_fault_pin_oe &&
    ((state_q == fsv_pkg::ST_RETRY) == $past(!i_masks.sag_retry || uv_set)))
    else $error("sag retry or pin wrong");

  a_ovp_noretry: assert property (
    (ovp_set && !retry_go and s_live) |=> faults_q.over &&
    o_fault_pin_oe && state_q == fsv_pkg::ST_RUN)
    else $error("overvoltage handling wrong");

  a_retry_length: assert property (
    s_retry_exit |-> $past(retry_age_q) == fsv_pkg::TMR_W'(RETRY_CYC - 1))
    else $error("retry interval length wrong");

  a_retry_dark: assert property (
    state_q == fsv_pkg::ST_RETRY |-> o_power == fsv_pkg::POWER_OFF)
    else $error("power left on during retry");

  a_set_over_clr: assert property (
    (clr_ev && uv_set && !por_ev) |=> faults_q.uv && o_fault_pin_oe)
    else $error("persisting fault lost on clear");

  a_cs_clear: assert property (
    (cs_s && !i_i2c_mode && !i_fault_clear && en_s && !por_ev &&
     faults_q != fsv_pkg::FAULTS_RST) |=> faults_q != fsv_pkg::FAULTS_RST)
    else $error("select pin cleared outside I2C mode");

endmodule

// ===== shared/fsv_pkg.sv
// ****************************************************************
// Supervisor constants and carriers
// ****************************************************************
package fsv_pkg;

  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
  localparam int unsigned SAG_FILTER_MS = 110;
  localparam int unsigned RETRY_MS      = 100;
  localparam int unsigned SAG_FILTER_CYC = CYC_PER_MS * SAG_FILTER_MS;
  localparam int unsigned RETRY_CYC      = CYC_PER_MS * RETRY_MS;
  localparam int          TMR_W          = 23;
  localparam int          BOOST_W        = 8;

  // Input undervoltage threshold select codes
  localparam logic [1:0] UV_SEL_OFF = 2'h0;
  localparam logic [1:0] UV_SEL_3V  = 2'h1;
  localparam logic [1:0] UV_SEL_5V  = 2'h2;
  localparam logic [1:0] UV_SEL_8V  = 2'h3;

  typedef enum logic [4:0]
  {
    ST_OFF   = 5'h01,
    ST_SOFT  = 5'h02,
    ST_RUN   = 5'h04,
    ST_RETRY = 5'h08,
    ST_STBY  = 5'h10
  } fsv_state_t;

  typedef struct packed
  {
    logic over;
    logic sag;
    logic uv;
  } fsv_faults_t;

  typedef struct packed
  {
    logic below_8v;
    logic below_5v;
    logic below_3v;
  } fsv_vin_cmp_t;

  typedef struct packed
  {
    logic uv;
    logic sag_retry;
    logic ovp_status;
  } fsv_masks_t;

  typedef struct packed
  {
    logic leds;
    logic boost;
    logic pl_fet;
  } fsv_power_t;

  localparam fsv_faults_t FAULTS_RST = '{over: 1'b0, sag: 1'b0, uv: 1'b0};
  localparam fsv_power_t  POWER_OFF  = '{leds: 1'b0, boost: 1'b0,
                                         pl_fet: 1'b0};

endpackage

// ===== logic/fsv_hold_timer.sv
`timescale 1ns/1ps
// ****************************************************************
// Hold timer: done after CYCLES enabled edges with run held high
// ****************************************************************
module fsv_hold_timer
#(
  parameter int unsigned CYCLES = 1
)
(
  input  wire logic i_ref_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_clk_en,
  input  wire logic i_run,
  output logic      o_done
);

  localparam logic [fsv_pkg::TMR_W-1:0] LAST =
    fsv_pkg::TMR_W'(CYCLES - 1);

  logic [fsv_pkg::TMR_W-1:0] cnt_q;
  logic                      done_q;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst || (i_clk_en && !i_run))
    begin
      cnt_q  <= '0;
      done_q <= 1'b0;
    end
    else if (i_clk_en && !done_q)
    begin
      if (cnt_q == LAST)
        done_q <= 1'b1;
      else
        cnt_q <= cnt_q + 1'b1;
    end
  end

  assign o_done = done_q;

endmodule

// ===== tb/fsv_host_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Host side: clear-bit write, select pin and enable pin
// ****************************************************************
module fsv_host_model
(
  input  wire logic i_ref_clk,
  output logic      o_fault_clear,
  output logic      o_chip_select_pin,
  output logic      o_i2c_mode,
  output logic      o_io_supply_enable_pin
);
  initial
  begin
    o_fault_clear          = 1'h0;
    o_chip_select_pin      = 1'h0;
    o_i2c_mode             = 1'h1;
    o_io_supply_enable_pin = 1'h0;
  end

  // One-cycle write of the clear bit
  task automatic write_clear();
    @(posedge i_ref_clk);
    #2 o_fault_clear = 1'h1;
    @(posedge i_ref_clk);
    #2 o_fault_clear = 1'h0;
  endtask

  // Level held past the synchroniser, then left low
  task automatic pulse_select(input logic i2c);
    o_i2c_mode = i2c;
    @(posedge i_ref_clk);
    #2 o_chip_select_pin = 1'h1;
    repeat (3) @(posedge i_ref_clk);
    #2 o_chip_select_pin = 1'h0;
    // Mode stays until the low level has crossed the synchroniser
    repeat (3) @(posedge i_ref_clk);
    #2 o_i2c_mode = 1'h1;
  endtask

  // Enable low is the power-cycle clear path
  task automatic set_enable(input logic en);
    @(posedge i_ref_clk);
    #2 o_io_supply_enable_pin = en;
  endtask
endmodule

// ===== tb/fsv_supervisor_tb_top.sv
`timescale 1ns/1ps
// ****************************************************************
// Bench top: shortened filter and retry counts
// ****************************************************************
module fsv_supervisor_tb_top;
  localparam int unsigned SAG = 20;
  localparam int unsigned RTY = 16;

  logic                  clk;
  logic                  rst;
  fsv_pkg::fsv_vin_cmp_t vin;
  logic                  core_uv;
  logic                  below_por;
  logic                  sag;
  logic                  over;
  logic [1:0]            sel;
  fsv_pkg::fsv_masks_t   masks;
  logic                  soft_done;
  logic                  adapt;
  logic [7:0]            adapt_t;
  logic [7:0]            init_t;
  wire logic             clr;
  wire logic             cs;
  wire logic             i2c;
  wire logic             en;
  fsv_pkg::fsv_faults_t  faults;
  fsv_pkg::fsv_state_t   state;
  fsv_pkg::fsv_power_t   power;
  logic [7:0]            target;
  logic                  pin_o;
  logic                  pin_oe;
  logic                  vclr;
  logic                  pclr;
  logic                  fault_line;
  fsv_pkg::fsv_state_t   exp_state;
  logic [2:0]            exp_faults;
  int                    error_cnt;
  int                    n_compared;
  int                    cyc_cnt;

  // Open-drain line with pull-up
  assign fault_line = pin_oe ? pin_o : 1'h1;

  initial clk = 1'h0;
  always #12.5 clk = ~clk;

  fsv_supervisor #(.SAG_FILTER_CYC(SAG), .RETRY_CYC(RTY)) u_fsv_supervisor
  (
    .i_ref_clk                       (clk),
    .i_sys_rst                       (rst),
    .i_clk_en                        (1'h1),
    .i_vin_cmp                       (vin),
    .i_core_supply_undervolt         (core_uv),
    .i_core_supply_below_por         (below_por),
    .i_boost_sag_cmp                 (sag),
    .i_boost_over_cmp                (over),
    .i_chip_select_pin               (cs),
    .i_io_supply_enable_pin          (en),
    .i_input_undervolt_threshold_sel (sel),
    .i_masks                         (masks),
    .i_i2c_mode                      (i2c),
    .i_fault_clear                   (clr),
    .i_soft_start_done               (soft_done),
    .i_adaptive_mode                 (adapt),
    .i_boost_adapt_target            (adapt_t),
    .i_boost_init_setting            (init_t),
    .o_faults                        (faults),
    .o_state                         (state),
    .o_power                         (power),
    .o_boost_target                  (target),
    .o_fault_pin_o                   (pin_o),
    .o_fault_pin_oe                  (pin_oe),
    .o_volatile_clear                (vclr),
    .o_preserved_clear               (pclr)
  );

  fsv_host_model u_fsv_host_model
  (
    .i_ref_clk              (clk),
    .o_fault_clear          (clr),
    .o_chip_select_pin      (cs),
    .o_i2c_mode             (i2c),
    .o_io_supply_enable_pin (en)
  );

  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk)
  begin
    cyc_cnt++;
    if (cyc_cnt == 4000)
    begin
      error_cnt++;
      summarize();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic chk_all();
    logic [2:0] pw;
    pw = (exp_state == fsv_pkg::ST_RUN) ? 3'h7 :
         (exp_state == fsv_pkg::ST_SOFT) ? 3'h3 : 3'h0;
    chk("state", 8'(exp_state), 8'(state));
    chk("faults", {5'h0, exp_faults}, {5'h0, faults});
    chk("power", {5'h0, pw}, {5'h0, power});
    chk("fault_line", {7'h0, ~|exp_faults}, {7'h0, fault_line});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic go_run();
    u_fsv_host_model.set_enable(1'h1);
    cyc(4);
    exp_state = fsv_pkg::ST_SOFT;
    chk_all();
    soft_done = 1'h1;
    cyc(1);
    soft_done = 1'h0;
    cyc(1);
    exp_state = fsv_pkg::ST_RUN;
    chk_all();
  endtask

  task automatic clear_write();
    u_fsv_host_model.write_clear();
    cyc(2);
  endtask

  task automatic run_sag(input logic masked);
    masks.sag_retry = masked;
    sag = 1'h1;
    cyc(SAG);
    chk_all();
    cyc(6);
    exp_faults = 3'h2;
    exp_state = masked ? fsv_pkg::ST_RUN : fsv_pkg::ST_RETRY;
    chk_all();
  endtask

  initial
  begin
    error_cnt = 0;
    n_compared = 0;
    cyc_cnt = 0;
    rst = 1'h1;
    vin = '0;
    core_uv = 1'h0;
    below_por = 1'h0;
    sag = 1'h0;
    over = 1'h0;
    sel = 2'h0;
    masks = '0;
    soft_done = 1'h0;
    adapt = 1'h0;
    adapt_t = 8'h00;
    init_t = 8'h00;
    void'($urandom(32'h07372FCD));
    repeat (5) @(posedge clk);
    #2;
    exp_state = fsv_pkg::ST_OFF;
    exp_faults = 3'h0;
    chk_all();
    chk("volatile_clear", 8'h01, {7'h0, vclr});
    rst = 1'h0;
    cyc(4);
    chk("preserved_clear", 8'h00, {7'h0, pclr});
    // ****************************************************************
    // Input undervoltage, every threshold code
    // ****************************************************************
    for (int k = 1; k < 4; k++)
    begin
      sel = k[1:0];
      go_run();
      vin[k-1] = 1'h1;
      cyc(4);
      exp_state = fsv_pkg::ST_RETRY;
      exp_faults = 3'h1;
      chk_all();
      vin = '0;
      cyc(RTY - 2);
      chk_all();
      cyc(1);
      exp_state = fsv_pkg::ST_SOFT;
      chk_all();
      clear_write();
      exp_faults = 3'h0;
      chk_all();
    end
    go_run();
    vin = '1;
    sel = 2'h0;
    cyc(6);
    chk_all();
    sel = 2'($urandom_range(3, 1));
    masks.uv = 1'h1;
    cyc(6);
    chk_all();
    masks.uv = 1'h0;
    cyc(4);
    exp_state = fsv_pkg::ST_RETRY;
    exp_faults = 3'h1;
    chk_all();
    clear_write();
    exp_faults = 3'h0;
    chk_all();
    cyc(RTY + 8);
    exp_faults = 3'h1;
    chk_all();
    vin = '0;
    cyc(RTY + 6);
    exp_state = fsv_pkg::ST_SOFT;
    chk_all();
    // ****************************************************************
    // Boost sag, select-pin clear, masked retry
    // ****************************************************************
    u_fsv_host_model.set_enable(1'h0);
    cyc(4);
    exp_state = fsv_pkg::ST_OFF;
    exp_faults = 3'h0;
    chk_all();
    go_run();
    run_sag(1'h0);
    sag = 1'h0;
    cyc(RTY + 6);
    exp_state = fsv_pkg::ST_SOFT;
    chk_all();
    u_fsv_host_model.pulse_select(1'h0);
    cyc(4);
    chk_all();
    u_fsv_host_model.pulse_select(1'h1);
    cyc(1);
    exp_faults = 3'h0;
    chk_all();
    go_run();
    run_sag(1'h1);
    clear_write();
    chk_all();
    sag = 1'h0;
    // Filter output trails the pin by the synchroniser and its own flop
    cyc(3);
    clear_write();
    exp_faults = 3'h0;
    chk_all();
    // ****************************************************************
    // Boost overvoltage and core supply loss
    // ****************************************************************
    masks.ovp_status = 1'h1;
    over = 1'h1;
    cyc(5);
    chk_all();
    masks.ovp_status = 1'h0;
    cyc(2);
    exp_faults = 3'h4;
    chk_all();
    over = 1'h0;
    cyc(5);
    chk_all();
    core_uv = 1'h1;
    cyc(4);
    exp_state = fsv_pkg::ST_STBY;
    chk_all();
    chk("volatile_clear", 8'h01, {7'h0, vclr});
    chk("preserved_clear", 8'h00, {7'h0, pclr});
    below_por = 1'h1;
    cyc(4);
    exp_faults = 3'h0;
    chk_all();
    chk("preserved_clear", 8'h01, {7'h0, pclr});
    core_uv = 1'h0;
    below_por = 1'h0;
    cyc(5);
    exp_state = fsv_pkg::ST_SOFT;
    chk_all();
    chk("volatile_clear", 8'h00, {7'h0, vclr});
    // ****************************************************************
    // Boost target selection
    // ****************************************************************
    for (int k = 0; k < 8; k++)
    begin
      adapt = 1'($urandom);
      adapt_t = 8'($urandom);
      init_t = 8'($urandom);
      cyc(2);
      chk("boost_target", adapt ? adapt_t : init_t, target);
    end
    summarize();
  end
endmodule
